// [hw/sbsc_pin_mux.sv]
// Pin multiplexer for the shared request/acknowledge pins and the chip-select pins.
// Assumes the request pin input is already synchronised by the caller.
`timescale 1ns/10ps
module sbsc_pin_mux (
  input wire sbsc_pkg::sbsc_ctrl_s ctrl_in,
  input wire logic req_pin_sync_in,
  input wire logic bus_release_ack_n_in,
  input wire logic port3_bit3_in,
  input wire logic [2:0] port3_bits0_2_in,
  input wire logic [2:0] chip_select_n_in,
  output logic input_port_bit3_out,
  output logic bus_release_req_n_out,
  output logic ack_pin_out,
  output logic [2:0] cs_pin_out
);

  // ==========================================================================
  // Shared pin selection.
  // ==========================================================================
  logic brel_active; // Release role is in force.

  // The release role needs both the enable and expansion mode, since single chip
  // mode keeps every shared pin a plain port.
  always_comb begin
    brel_active = ctrl_in.bus_release_en & ctrl_in.bus_mode_sel;
    input_port_bit3_out = req_pin_sync_in;
    bus_release_req_n_out = brel_active ? req_pin_sync_in : 1'b1;
    ack_pin_out = brel_active ? bus_release_ack_n_in : port3_bit3_in;
  end

  // ==========================================================================
  // Chip-select lines, one per enable bit.
  // ==========================================================================
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_cs
      always_comb begin
        cs_pin_out[g] = (ctrl_in.chip_select_en[g] & ctrl_in.bus_mode_sel) ?
                        chip_select_n_in[g] : port3_bits0_2_in[g];
      end
    end
  endgenerate

endmodule

// [hw/sbsc_pkg.sv]
// Package for the system bus and stack control bank: offsets, fields, resets, carriers.
// Assumes a 32-bit APB slave in front of byte-wide control registers.
package sbsc_pkg;

  // ==========================================================================
  // Register offsets.
  // ==========================================================================
  // Register indices as printed; byte address is four times the index.
  localparam logic [15:0] SBSC_IDX_MODE = 16'hFF00;
  localparam logic [15:0] SBSC_IDX_STACK = 16'hFF01;
  localparam logic [15:0] SBSC_IDX_BREL = 16'hFF02;
  // Byte addresses on the APB side.
  localparam logic [17:0] SBSC_ADDR_MODE = {SBSC_IDX_MODE, 2'b00};
  localparam logic [17:0] SBSC_ADDR_STACK = {SBSC_IDX_STACK, 2'b00};
  localparam logic [17:0] SBSC_ADDR_BREL = {SBSC_IDX_BREL, 2'b00};

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int SBSC_BIT_BUS_MODE = 7;
  localparam int SBSC_BIT_CPU_MODE = 6;
  localparam int SBSC_RSV_HI = 5;
  localparam int SBSC_RSV_LO = 3;
  localparam int SBSC_CS_HI = 2;
  localparam int SBSC_CS_LO = 0;
  localparam int SBSC_BIT_BREL_EN = 7;
  localparam int SBSC_WAIT_HI = 6;
  localparam int SBSC_WAIT_LO = 4;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [7:0] SBSC_RST_STACK = 8'h00;
  localparam logic SBSC_RST_BREL_EN = 1'b0;
  localparam logic [2:0] SBSC_RST_WAIT = 3'h0;
  localparam logic [2:0] SBSC_RST_RSV = 3'h0;
  localparam logic [2:0] SBSC_RST_CS = 3'h0;
  localparam logic SBSC_RST_CPU_MODE = 1'b0;
  localparam logic SBSC_RST_BUS_MODE = 1'b0;
  // Page size in address bits (64K blocks).
  localparam int SBSC_PAGE_BITS = 16;

  // Control state that leaves the register file as one carrier.
  typedef struct packed {
    logic bus_mode_sel;          // One selects expansion mode.
    logic cpu_mode_sel;          // One selects maximum mode.
    logic [2:0] chip_select_en;  // Per-line chip-select enables.
    logic bus_release_en;        // Shared pins act as bus release pair.
    logic [2:0] wait_state_sel;  // Wait selector code.
    logic [7:0] stack_page;      // Page for stack accesses.
  } sbsc_ctrl_s;

endpackage

// [hw/sbsc_top.sv]
// System bus and stack control bank: APB registers, mode straps, pin muxing.
// Assumes one 100 MHz clock, an APB master on the same clock, pins from outside.
//
// Operation
// - Request and acknowledge share port pins.
// - Reset leaves shared pins as ports.
// - Writing enable one gives release role in expansion mode.
// - Release enable is bit seven, cleared.
// - Eight-bit read/write stack page register.
// - Stack page resets to zero.
// - Internal RAM lives in page zero.
// - Page is a 64K block.
// - Single chip mode ignores chip selects.
// - Bus and CPU mode bits, reset zero.
// - External program forces expansion, read-only.
// - Chip select enables drive pins.
// - Wait selector gives half-clock states.
`timescale 1ns/10ps
module sbsc_top (
  input wire logic clk_in,
  input wire logic resetn_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Mode strap pin, high selects external program mode.
  input wire logic external_program_mode_in,
  // Shared request pin and bus sequencer acknowledge.
  input wire logic req_pin_in,
  input wire logic bus_release_ack_n_in,
  input wire logic port3_bit3_in,
  input wire logic [2:0] out_port3_bits0_2_in,
  input wire logic [2:0] chip_select_n_in,
  input wire logic [15:0] stack_offset_in,
  output logic input_port_bit3_out,
  output logic bus_release_req_n_out,
  output logic out_port3_bit3_out,
  output logic [2:0] cs_pin_out,
  output logic [3:0] wait_states_out,
  output logic [23:0] stack_addr_out,
  output logic bus_mode_sel_out,
  output logic cpu_mode_sel_out,
  output logic external_program_mode_out
);

  // ==========================================================================
  // Strap capture.
  // ==========================================================================
  logic strap_s1; // First stage, read only by the second.
  logic strap_s2; // Second stage.
  logic strap_s3; // Third stage.
  logic strap_done; // Strap has been latched since reset.
  logic ext_prog; // Latched external program mode.
  logic next_strap_done;
  logic next_ext_prog;
  logic [2:0] strap_fill; // Ones shift in behind reset; top bit marks a full pipeline.

  // The strap is a pin, so it passes three stages and is taken only once the
  // last two agree; the mode then stays put until the next reset.
  always_comb begin
    next_strap_done = strap_done;
    next_ext_prog = ext_prog;
    // Stage three holds a real pin sample only from the third edge on, so the
    // reset zeros in stages two and three must not count as agreement.
    if (!strap_done && strap_fill[2] && (strap_s2 == strap_s3)) begin
      next_strap_done = 1'b1;
      next_ext_prog = strap_s3;
    end
  end

  // Registers the strap pipeline.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_s3 <= 1'b0;
      strap_fill <= 3'h0;
      strap_done <= 1'b0;
      ext_prog <= 1'b0;
    end else begin
      strap_s1 <= external_program_mode_in;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      strap_fill <= {strap_fill[1:0], 1'b1};
      strap_done <= next_strap_done;
      ext_prog <= next_ext_prog;
    end
  end

  // ==========================================================================
  // Request pin synchroniser.
  // ==========================================================================
  logic req_s1; // First stage, read only by the second.
  logic req_s2; // Second stage.
  logic req_s3; // Third stage.
  logic req_clean; // Accepted level.
  logic next_req_clean;

  // A change counts only when stages two and three agree.
  always_comb begin
    next_req_clean = (req_s2 == req_s3) ? req_s3 : req_clean;
  end

  // Reset parks the chain at the idle level so no false request follows reset.
  // Registers the request pipeline; idle level is high (not requesting).
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_s1 <= 1'b1;
      req_s2 <= 1'b1;
      req_s3 <= 1'b1;
      req_clean <= 1'b1;
    end else begin
      req_s1 <= req_pin_in;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      req_clean <= next_req_clean;
    end
  end

  // ==========================================================================
  // Control registers.
  // ==========================================================================
  logic bus_mode; // Stored bus mode bit.
  logic cpu_mode; // CPU mode bit.
  logic [2:0] rsv; // Reserved storage bits.
  logic [2:0] cs_en; // Chip-select enables.
  logic [7:0] stack_page; // Stack page register.
  logic brel_en; // Bus release enable.
  logic [2:0] wait_sel; // Wait selector.
  logic next_bus_mode;
  logic next_cpu_mode;
  logic [2:0] next_rsv;
  logic [2:0] next_cs_en;
  logic [7:0] next_stack_page;
  logic next_brel_en;
  logic [2:0] next_wait_sel;
  logic wr_go; // Access phase of a write.
  logic [17:0] word_addr; // Byte address within the bank.
  logic addr_hit; // Address maps to a register.
  logic in_range; // Upper address bits are zero.

  assign in_range = (paddr_in[31:18] == 14'h0000);
  assign word_addr = paddr_in[17:0];
  assign addr_hit = in_range && ((word_addr == sbsc_pkg::SBSC_ADDR_MODE) ||
                    (word_addr == sbsc_pkg::SBSC_ADDR_STACK) ||
                    (word_addr == sbsc_pkg::SBSC_ADDR_BREL));
  assign wr_go = psel_in && penable_in && pwrite_in && pstrb_in[0] && addr_hit;

  // Next values of the control bits; only byte lane 0 carries data.
  always_comb begin
    next_bus_mode = bus_mode;
    next_cpu_mode = cpu_mode;
    next_rsv = rsv;
    next_cs_en = cs_en;
    next_stack_page = stack_page;
    next_brel_en = brel_en;
    next_wait_sel = wait_sel;
    // Until the strap is known, the reset values follow it so they are right
    // from the first accepted access.
    if (!strap_done) begin
      next_bus_mode = next_ext_prog;
      next_cs_en = {2'b00, next_ext_prog};
    end else if (wr_go) begin
      if (word_addr == sbsc_pkg::SBSC_ADDR_MODE) begin
        next_bus_mode = ext_prog ? 1'b1 : pwdata_in[sbsc_pkg::SBSC_BIT_BUS_MODE];
        next_cpu_mode = pwdata_in[sbsc_pkg::SBSC_BIT_CPU_MODE];
        next_rsv = pwdata_in[sbsc_pkg::SBSC_RSV_HI:sbsc_pkg::SBSC_RSV_LO];
        next_cs_en = pwdata_in[sbsc_pkg::SBSC_CS_HI:sbsc_pkg::SBSC_CS_LO];
      end else if (word_addr == sbsc_pkg::SBSC_ADDR_STACK) begin
        next_stack_page = pwdata_in[7:0];
      end else begin
        next_brel_en = pwdata_in[sbsc_pkg::SBSC_BIT_BREL_EN];
        next_wait_sel = pwdata_in[sbsc_pkg::SBSC_WAIT_HI:sbsc_pkg::SBSC_WAIT_LO];
      end
    end
  end

  // Registers the control bits; reset values are constants.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // Internal program mode value; the strap may override it at latch time.
      bus_mode <= sbsc_pkg::SBSC_RST_BUS_MODE;
      cpu_mode <= sbsc_pkg::SBSC_RST_CPU_MODE;
      rsv <= sbsc_pkg::SBSC_RST_RSV;
      cs_en <= sbsc_pkg::SBSC_RST_CS;
      stack_page <= sbsc_pkg::SBSC_RST_STACK;
      brel_en <= sbsc_pkg::SBSC_RST_BREL_EN;
      wait_sel <= sbsc_pkg::SBSC_RST_WAIT;
    end else begin
      bus_mode <= next_bus_mode;
      cpu_mode <= next_cpu_mode;
      rsv <= next_rsv;
      cs_en <= next_cs_en;
      stack_page <= next_stack_page;
      brel_en <= next_brel_en;
      wait_sel <= next_wait_sel;
    end
  end

  // ==========================================================================
  // APB read path and answer.
  // ==========================================================================
  logic [31:0] rd_data; // Read data of the addressed register.
  logic [31:0] next_prdata;

  // Read mux; bits above the byte read as zero.
  // The mux reads next values: they equal the stored ones outside a write, and
  // in the stall cycle that latches the strap they already carry the mode that reset settles on.
  always_comb begin
    rd_data = 32'h0000_0000;
    if (word_addr == sbsc_pkg::SBSC_ADDR_MODE) begin
      rd_data[7:0] = {next_bus_mode, next_cpu_mode, next_rsv, next_cs_en};
    end else if (word_addr == sbsc_pkg::SBSC_ADDR_STACK) begin
      rd_data[7:0] = next_stack_page;
    end else if (word_addr == sbsc_pkg::SBSC_ADDR_BREL) begin
      rd_data[7:0] = {next_brel_en, next_wait_sel, 4'h0};
    end
    next_prdata = prdata_out;
    // Capture in setup and in every stalled access cycle, so a read that waits
    // out the strap returns the settled reset values rather than stale ones.
    if (psel_in && !pwrite_in && (!penable_in || !pready_out)) begin
      next_prdata = addr_hit ? rd_data : 32'h0000_0000;
    end
  end

  // Read data is captured in the setup cycle so it stands through access.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h0000_0000;
    end else begin
      prdata_out <= next_prdata;
    end
  end

  // A master that starts at once after reset simply sees extra wait states;
  // the error flag is shown during them too, but is only valid with ready.
  // Stalls only until the strap is known, so reset values are settled first.
  assign pready_out = strap_done;
  assign pslverr_out = psel_in && penable_in && !addr_hit;

  // ==========================================================================
  // Outputs and submodules.
  // ==========================================================================
  sbsc_pkg::sbsc_ctrl_s ctrl; // Control carrier.

  always_comb begin
    ctrl.bus_mode_sel = bus_mode;
    ctrl.cpu_mode_sel = cpu_mode;
    ctrl.chip_select_en = cs_en;
    ctrl.bus_release_en = brel_en;
    ctrl.wait_state_sel = wait_sel;
    ctrl.stack_page = stack_page;
  end

  assign bus_mode_sel_out = bus_mode;
  assign cpu_mode_sel_out = cpu_mode;
  assign external_program_mode_out = ext_prog;
  assign stack_addr_out = {stack_page, stack_offset_in};

  // The pin mux sees the filtered request, never the raw pin.
  sbsc_pin_mux u_pin_mux (
    .ctrl_in(ctrl),
    .req_pin_sync_in(req_clean),
    .bus_release_ack_n_in(bus_release_ack_n_in),
    .port3_bit3_in(port3_bit3_in),
    .port3_bits0_2_in(out_port3_bits0_2_in),
    .chip_select_n_in(chip_select_n_in),
    .input_port_bit3_out(input_port_bit3_out),
    .bus_release_req_n_out(bus_release_req_n_out),
    .ack_pin_out(out_port3_bit3_out),
    .cs_pin_out(cs_pin_out)
  );

  // The wait count matters only to the external bus sequencer.
  sbsc_wait_decode u_wait (
    .wait_state_sel_in(wait_sel),
    .bus_mode_sel_in(bus_mode),
    .wait_states_out(wait_states_out)
  );

endmodule

// [hw/sbsc_wait_decode.sv]
// Wait selector decode into a count of half-clock wait states.
// Assumes the bus sequencer consumes the count; no wait is inserted in single chip mode.
`timescale 1ns/10ps
module sbsc_wait_decode (
  input wire logic [2:0] wait_state_sel_in,
  input wire logic bus_mode_sel_in,
  output logic [3:0] wait_states_out
);

  // ==========================================================================
  // Decode.
  // ==========================================================================
  // Code n gives 2n half-clock states; single chip mode has no external cycles.
  always_comb begin
    wait_states_out = bus_mode_sel_in ? {wait_state_sel_in, 1'b0} : 4'h0;
  end

endmodule

// [verification/sbsc_dma_model.sv]
// Behavioural external DMA master that drives the shared request pin.
// Assumes the pin has a pull-up, so a released request reads high.
`timescale 1ns/10ps
module sbsc_dma_model (
  input wire logic clk_in,
  input wire logic want_bus_in,
  output logic req_pin_out
);
  // ==========================================================================
  // Request pin.
  // ==========================================================================
  // Request low only when the master wants the bus.
  // The pull-up makes the idle level high; the release is one edge late.
  always_ff @(posedge clk_in) begin
    req_pin_out <= !want_bus_in;
  end
endmodule

// [verification/sbsc_top_chk.sv]
// Checker of the control bank's port relations.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/10ps
module sbsc_top_chk (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic port3_bit3_in,
  input wire logic [2:0] out_port3_bits0_2_in,
  input wire logic [15:0] stack_offset_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic input_port_bit3_out,
  input wire logic bus_release_req_n_out,
  input wire logic out_port3_bit3_out,
  input wire logic [2:0] cs_pin_out,
  input wire logic [3:0] wait_states_out,
  input wire logic [23:0] stack_addr_out,
  input wire logic bus_mode_sel_out,
  input wire logic external_program_mode_out
);
  // ==========================================================================
  // Helpers and assertions.
  // ==========================================================================
  logic mapped; // High when the address hits one of the three registers.
  logic wr_acc; // Access phase of a write, kept as a signal for the history check.
  assign mapped = (paddr_in[31:18] == 14'h0000) &&
                  ((paddr_in[17:0] == sbsc_pkg::SBSC_ADDR_MODE) ||
                   (paddr_in[17:0] == sbsc_pkg::SBSC_ADDR_STACK) ||
                   (paddr_in[17:0] == sbsc_pkg::SBSC_ADDR_BREL));
  assign wr_acc = psel_in && penable_in && pwrite_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_stack_low_offset: assert property (stack_addr_out[15:0] == stack_offset_in)
    else $error("stack address low half differs from offset");
  a_stack_page_hold: assert property (!$past(wr_acc) |-> $stable(stack_addr_out[23:16]))
    else $error("stack page moved without a write");
  a_req_single_chip: assert property (!bus_mode_sel_out |-> bus_release_req_n_out)
    else $error("release request active in single chip mode");
  a_req_follows_pin: assert property (!bus_release_req_n_out |-> !input_port_bit3_out)
    else $error("release request without a low request pin");
  a_cs_single_chip: assert property (!bus_mode_sel_out |->
    cs_pin_out == out_port3_bits0_2_in) else $error("chip-select pin left port role");
  a_ack_single_chip: assert property (!bus_mode_sel_out |->
    out_port3_bit3_out == port3_bit3_in) else $error("ack pin left port role");
  a_wait_even_max: assert property (wait_states_out[0] == 1'b0 && wait_states_out <= 4'hE)
    else $error("wait count odd or above fourteen");
  a_ext_forces_exp: assert property (external_program_mode_out && pready_out |->
    bus_mode_sel_out) else $error("bus mode not forced in external program mode");
  a_unmapped_err: assert property (psel_in && penable_in && !mapped |-> pslverr_out)
    else $error("unmapped access without error");
  a_mapped_no_err: assert property (psel_in && penable_in && mapped |-> !pslverr_out)
    else $error("mapped access flagged as error");
  a_read_upper_zero: assert property (prdata_out[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_ready_stays: assert property (pready_out |=> pready_out)
    else $error("ready dropped after strap latch");
endmodule
bind sbsc_top sbsc_top_chk u_chk (.clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .port3_bit3_in, .out_port3_bits0_2_in, .stack_offset_in, .prdata_out, .pready_out,
  .pslverr_out, .input_port_bit3_out, .bus_release_req_n_out, .out_port3_bit3_out, .cs_pin_out,
  .wait_states_out, .stack_addr_out, .bus_mode_sel_out, .external_program_mode_out);

// [verification/system_bus_stack_control_tb.sv]
// Self-checking bench of the control bank over APB with a DMA master model.
// Assumes the package and design files are compiled first.
`timescale 1ns/10ps
module system_bus_stack_control_tb;
  localparam logic [31:0] A_MODE = 32'(sbsc_pkg::SBSC_ADDR_MODE);
  localparam logic [31:0] A_STK = 32'(sbsc_pkg::SBSC_ADDR_STACK);
  localparam logic [31:0] A_BREL = 32'(sbsc_pkg::SBSC_ADDR_BREL);
  logic clk_in = 1'b0, resetn_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [31:0] paddr_in = 32'h0, pwdata_in = 32'h0, r;
  logic [3:0] pstrb_in = 4'h0, wait_states_out;
  logic external_program_mode_in = 1'b0, bus_release_ack_n_in = 1'b1, port3_bit3_in = 1'b0;
  logic want = 1'b0, e, req_pin_in, pready_out, pslverr_out, input_port_bit3_out;
  logic bus_release_req_n_out, out_port3_bit3_out, bus_mode_sel_out, cpu_mode_sel_out;
  logic external_program_mode_out;
  logic [2:0] out_port3_bits0_2_in = 3'h5, chip_select_n_in = 3'h2, cs_pin_out;
  logic [15:0] stack_offset_in = 16'hF800;
  logic [23:0] stack_addr_out;
  logic [31:0] prdata_out;
  int fail_count = 0, checks_done = 0, n;
  sbsc_top dut (.clk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .external_program_mode_in, .req_pin_in,
    .bus_release_ack_n_in, .port3_bit3_in, .out_port3_bits0_2_in, .chip_select_n_in,
    .stack_offset_in, .input_port_bit3_out, .bus_release_req_n_out, .out_port3_bit3_out,
    .cs_pin_out, .wait_states_out, .stack_addr_out, .bus_mode_sel_out, .cpu_mode_sel_out,
    .external_program_mode_out);
  sbsc_dma_model u_dma (.clk_in, .want_bus_in(want), .req_pin_out(req_pin_in));
  // The clock toggles every half period of 5 ns.
  always #5 clk_in = !clk_in;
  // ==========================================================================
  // Tasks.
  // ==========================================================================
  // Closing report, the only place where the run ends.
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compares a value with its expectation by case equality.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request is held until ready is sampled high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end else begin
      r = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hF);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(r, {24'h0, exp});
  endtask
  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    rdc(A_MODE, 8'h00);
    rdc(A_STK, 8'h00);
    rdc(A_BREL, 8'h00);
    chk({31'h0, external_program_mode_out}, 32'h0);
    want <= 1'b1;
    for (int i = 0; i < 20 && input_port_bit3_out !== 1'b0; i++) @(posedge clk_in);
    chk({31'h0, input_port_bit3_out}, 32'h0);
    chk({31'h0, bus_release_req_n_out}, 32'h1);
    wr(A_STK, 8'hA5);
    rdc(A_STK, 8'hA5);
    chk({8'h0, stack_addr_out}, 32'h00A5F800);
    wr(A_MODE, 8'h7F);
    rdc(A_MODE, 8'h7F);
    chk({29'h0, cs_pin_out}, 32'h5);
    chk({31'h0, cpu_mode_sel_out}, 32'h1);
    wr(A_MODE, 8'hC7);
    rdc(A_MODE, 8'hC7);
    chk({31'h0, bus_mode_sel_out}, 32'h1);
    chk({29'h0, cs_pin_out}, 32'h2);
    wr(A_MODE, 8'hC3);
    chk({29'h0, cs_pin_out}, 32'h6);
    wr(A_STK, 8'h27);
    chk({8'h0, stack_addr_out}, 32'h0027F800);
    for (int c = 0; c < 8; c++) begin
      wr(A_BREL, {1'b0, 3'(c), 4'h0});
      chk({28'h0, wait_states_out}, 32'(2 * c));
    end
    wr(A_BREL, 8'h80);
    rdc(A_BREL, 8'h80);
    for (int i = 0; i < 20 && bus_release_req_n_out !== 1'b0; i++) @(posedge clk_in);
    chk({31'h0, bus_release_req_n_out}, 32'h0);
    bus_release_ack_n_in <= 1'b0;
    port3_bit3_in <= 1'b1;
    @(posedge clk_in);
    chk({31'h0, out_port3_bit3_out}, 32'h0);
    wr(A_MODE, 8'h47);
    chk({31'h0, bus_release_req_n_out}, 32'h1);
    chk({31'h0, out_port3_bit3_out}, 32'h1);
    apb(1'b0, 32'h0003FC0C, 32'h0, 4'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    apb(1'b1, A_STK, 32'h11, 4'h0);
    rdc(A_STK, 8'h27);
    resetn_in <= 1'b0;
    external_program_mode_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rdc(A_MODE, 8'h81);
    rdc(A_STK, 8'h00);
    chk({31'h0, external_program_mode_out}, 32'h1);
    wr(A_MODE, 8'h00);
    rdc(A_MODE, 8'h80);
    wrap_up();
  end
  // Cuts a hang short and reports it as a mismatch.
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    wrap_up();
  end
endmodule
